// [rtl/e1fas_consts.svh]
`ifndef E1FAS_CONSTS_SVH
`define E1FAS_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses on the 8-bit register port)
// ----------------------------------------------------------------
`define E1FAS_OFS_FRAMING_SELECT 8'h00
`define E1FAS_OFS_IRQ_STATUS 8'h01
`define E1FAS_OFS_IRQ_MASK 8'h02
`define E1FAS_OFS_ALIGN_STATE 8'h03

// ----------------------------------------------------------------
// framing_select fields and reset value
// ----------------------------------------------------------------
`define E1FAS_FS_RESET 8'h00
`define E1FAS_FS_IW_EN 7
`define E1FAS_FS_TX_CRC_ERR 6
`define E1FAS_FS_CAS_HI 5
`define E1FAS_FS_CAS_LO 4
`define E1FAS_FS_CRC_HI 3
`define E1FAS_FS_CRC_LO 2
`define E1FAS_FS_EXTRA 1
`define E1FAS_FS_ALG 0

// ----------------------------------------------------------------
// interrupt status / mask bits
// ----------------------------------------------------------------
`define E1FAS_IRQ_FAS 0
`define E1FAS_IRQ_CRC 1
`define E1FAS_IRQ_CAS 2
`define E1FAS_IRQ_IW 3
`define E1FAS_IRQ_RESET 4'h0

// ----------------------------------------------------------------
// frame geometry and patterns
// ----------------------------------------------------------------
`define E1FAS_BITS_LAST 8'hFF
`define E1FAS_FAS_PATTERN 7'h1B
`define E1FAS_FAS_END_BIT 8'h07
`define E1FAS_FAS_NEXT_BIT 8'h08
`define E1FAS_TS0_B1_BIT 8'h00
`define E1FAS_TS0_B2_BIT 8'h01
`define E1FAS_TS16_B4_BIT 8'h83
`define E1FAS_CRC_MF_PATTERN 6'h0B
`define E1FAS_CAS_MF_PATTERN 4'h0
`define E1FAS_CAS_MISS_16 4'hF
`define E1FAS_CAS_MISS_2 4'h1

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define E1FAS_CLK_KHZ 25000
`define E1FAS_CRC_WIN_MS 8
`define E1FAS_IW_MS 400
`define E1FAS_CRC_WIN_CYC (`E1FAS_CRC_WIN_MS * `E1FAS_CLK_KHZ)
`define E1FAS_IW_CYC (`E1FAS_IW_MS * `E1FAS_CLK_KHZ)

`endif

// [rtl/e1fas_pkg.sv]
package e1fas_pkg;

  // basic frame search states, gray coded along hunt -> sync
  typedef enum logic [2:0] {
    E1FAS_HUNT = 3'b000,
    E1FAS_NFAS = 3'b001,
    E1FAS_FAS = 3'b011,
    E1FAS_XNFAS = 3'b010,
    E1FAS_XFAS = 3'b110,
    E1FAS_SYNC = 3'b111,
    E1FAS_HOLD = 3'b100
  } e1fas_state_t;

  typedef logic [1:0] e1fas_sel_t;

endpackage

// [rtl/e1fas_crcmf.sv]
`timescale 1ns/10ps
`default_nettype none
`include "e1fas_consts.svh"

module e1fas_crcmf #(
  parameter int WIN_CYC = `E1FAS_CRC_WIN_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic enable,
  input wire e1fas_pkg::e1fas_sel_t need,
  input wire logic si_tick,
  input wire logic si_bit,
  output logic aligned
);
  import e1fas_pkg::*;

  logic [5:0] hist;
  logic [1:0] hits;
  logic [23:0] win_cnt;
  logic run;
  wire match = si_tick && ({hist[4:0], si_bit} == `E1FAS_CRC_MF_PATTERN); // RULE_08
  wire [1:0] next_hits = hits + 2'h1;
  wire win_over = run && (win_cnt >= 24'(WIN_CYC - 1));

  // count alignment signals inside one window; on expiry the window closes and the next signal opens a new one
  always_ff @(posedge clock)
  begin
    if (!rst_n || !enable)
    begin
      hist <= 6'h0;
      hits <= 2'h0;
      win_cnt <= 24'h0;
      run <= 1'b0;
      aligned <= 1'b0; // RULE_09
    end
    else if (!aligned)
    begin
      if (si_tick)
        hist <= {hist[4:0], si_bit};
      if (match)
      begin
        hits <= next_hits;
        run <= 1'b1;
        win_cnt <= win_over ? 24'h0 : win_cnt + 24'h1;
        aligned <= (win_over ? 2'h1 : next_hits) >= need; // RULE_10
        if (win_over)
          hits <= 2'h1;
      end
      else if (win_over)
      begin
        run <= 1'b0;
        hits <= 2'h0;
        win_cnt <= 24'h0;
      end
      else if (run)
        win_cnt <= win_cnt + 24'h1;
    end
  end
endmodule // e1fas_crcmf
`default_nettype wire

// [rtl/e1fas_casmf.sv]
`timescale 1ns/10ps
`default_nettype none
`include "e1fas_consts.svh"

module e1fas_casmf (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic enable,
  input wire e1fas_pkg::e1fas_sel_t mode,
  input wire logic ts16_tick,
  input wire logic [3:0] nibble,
  output logic aligned
);
  import e1fas_pkg::*;

  logic [3:0] miss_cnt;
  wire off = (mode == 2'h0) || (mode == 2'h3); // RULE_05
  wire [3:0] need = (mode == 2'h1) ? `E1FAS_CAS_MISS_16 : `E1FAS_CAS_MISS_2; // RULE_06 RULE_07
  wire hit = (nibble == `E1FAS_CAS_MF_PATTERN);

  // count consecutive frames without the pattern, saturating at 15
  always_ff @(posedge clock)
  begin
    if (!rst_n || !enable || off)
    begin
      miss_cnt <= 4'h0;
      aligned <= 1'b0;
    end
    else if (ts16_tick && !aligned)
    begin
      if (hit)
      begin
        aligned <= (miss_cnt >= need); // RULE_06 RULE_07
        miss_cnt <= 4'h0;
      end
      else if (miss_cnt != 4'hF)
        miss_cnt <= miss_cnt + 4'h1;
    end
  end
endmodule // e1fas_casmf
`default_nettype wire

// [rtl/e1fas_top.sv]
// Functional notes
// RULE_01: no CRC alignment in 400 ms: interworking interrupt
// RULE_02: bit 7 enables interworking detection, resets 0
// RULE_03: transmit CRC error inverts C1 each multiframe
// RULE_04: CRC error forcing ignored without transmit CRC
// RULE_05: CAS select 00 or 11 disables CAS
// RULE_06: CAS 01: 15 misses then pattern aligns
// RULE_07: CAS 10: one miss then pattern aligns
// RULE_08: CRC pattern checked on non-FAS international bits
// RULE_09: CRC select 00 disables CRC alignment
// RULE_10: CRC select needs 1/2/3 signals in 8 ms
// RULE_11: extra check verifies two more frames first
// RULE_12: bit 0 picks search algorithm one or two
// RULE_13: search starts hunting the 7-bit FAS pattern
// RULE_14: next frame bit 2 must be one
// RULE_15: third frame must hold FAS again
// RULE_16: three checks pass without extra: declare sync
// RULE_17: algorithm two holds off one frame on fail
// RULE_18: frames are 256 bits, 32 timeslots, alternating
`timescale 1ns/10ps
`default_nettype none
`include "e1fas_consts.svh"

module e1fas_top #(
  parameter int CRC_WIN_CYC = `E1FAS_CRC_WIN_CYC,
  parameter int IW_CYC = `E1FAS_IW_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rd_data,
  output logic irq,
  input wire logic line_clk,
  input wire logic line_data,
  input wire logic tx_bit_in,
  input wire logic tx_c1_slot,
  input wire logic tx_crc_mf_on,
  output logic tx_bit_out,
  output logic fas_in_sync,
  output logic crc_mf_aligned,
  output logic cas_mf_aligned,
  output logic non_crc_far_end
);
  import e1fas_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // the crc select enables its aligner unless it reads zero
  function automatic logic sel_on(input e1fas_sel_t sel);
    sel_on = (sel != 2'h0);
  endfunction

  // ----------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------
  logic [7:0] framing_select;
  logic [3:0] irq_status;
  logic [3:0] irq_mask;
  logic [3:0] events;

  wire hit_fs = (reg_addr == `E1FAS_OFS_FRAMING_SELECT);
  wire hit_st = (reg_addr == `E1FAS_OFS_IRQ_STATUS);
  wire hit_mk = (reg_addr == `E1FAS_OFS_IRQ_MASK);
  wire hit_al = (reg_addr == `E1FAS_OFS_ALIGN_STATE);

  wire iw_en = framing_select[`E1FAS_FS_IW_EN]; // RULE_02
  wire tx_crc_err = framing_select[`E1FAS_FS_TX_CRC_ERR];
  wire [1:0] cas_sel = framing_select[`E1FAS_FS_CAS_HI:`E1FAS_FS_CAS_LO];
  wire [1:0] crc_sel = framing_select[`E1FAS_FS_CRC_HI:`E1FAS_FS_CRC_LO];
  wire extra_chk = framing_select[`E1FAS_FS_EXTRA];
  wire alg_two = framing_select[`E1FAS_FS_ALG]; // RULE_12

  // unmapped addresses read zero
  logic [7:0] rd_mux;
  always_comb
  begin
    if (hit_fs)
      rd_mux = framing_select;
    else if (hit_st)
      rd_mux = {4'h0, irq_status};
    else if (hit_mk)
      rd_mux = {4'h0, irq_mask};
    else if (hit_al)
      rd_mux = {4'h0, non_crc_far_end, cas_mf_aligned, crc_mf_aligned, fas_in_sync};
    else
      rd_mux = 8'h00;
  end

  // write-one-to-clear; a new event in the same cycle wins over the clear
  wire [3:0] st_clr = (reg_wr && hit_st) ? reg_wr_data[3:0] : 4'h0;
  wire [3:0] next_status = (irq_status & ~st_clr) | events;

  // register file; read data stands in the cycle after the strobe only
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      framing_select <= `E1FAS_FS_RESET;
      irq_mask <= `E1FAS_IRQ_RESET;
      irq_status <= `E1FAS_IRQ_RESET;
      reg_rd_data <= 8'h00;
      irq <= 1'b0;
    end
    else
    begin
      if (reg_wr && hit_fs)
        framing_select <= reg_wr_data;
      if (reg_wr && hit_mk)
        irq_mask <= reg_wr_data[3:0];
      irq_status <= next_status;
      reg_rd_data <= reg_rd ? rd_mux : 8'h00;
      irq <= |(next_status & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // line input synchronisers
  // ----------------------------------------------------------------
  logic lc_s1;
  logic lc_s2;
  logic lc_s3;
  logic lc_lvl;
  logic ld_s1;
  logic ld_s2;
  logic ld_s3;

  // a clock level counts once the second and third stages agree
  wire lc_change = (lc_s2 == lc_s3) && (lc_s3 != lc_lvl);
  wire bit_tick = lc_change && lc_s3;
  wire rx_bit = ld_s3;

  // three stages on both pins; the line clock is far slower than ours
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      {lc_s1, lc_s2, lc_s3, lc_lvl} <= 4'h0;
      {ld_s1, ld_s2, ld_s3} <= 3'h0;
    end
    else
    begin
      {lc_s1, lc_s2, lc_s3} <= {line_clk, lc_s1, lc_s2};
      {ld_s1, ld_s2, ld_s3} <= {line_data, ld_s1, ld_s2};
      if (lc_change)
        lc_lvl <= lc_s3;
    end
  end

  // ----------------------------------------------------------------
  // basic frame search
  // ----------------------------------------------------------------
  e1fas_state_t state;
  e1fas_state_t next_state;
  logic [7:0] bit_pos;
  logic fas_frame;
  logic [6:0] shreg;
  logic [7:0] next_pos;
  logic next_fas_frame;

  wire [6:0] window_bits = {shreg[5:0], rx_bit};
  wire pat_now = (window_bits == `E1FAS_FAS_PATTERN);
  wire at_b2 = (bit_pos == `E1FAS_TS0_B2_BIT) && !fas_frame;
  wire at_fas = (bit_pos == `E1FAS_FAS_END_BIT) && fas_frame;
  wire at_si = (bit_pos == `E1FAS_TS0_B1_BIT) && !fas_frame;
  wire at_ts16 = (bit_pos == `E1FAS_TS16_B4_BIT);

  // bit and frame position; a hunt hit re-anchors both
  always_comb
  begin
    next_pos = bit_pos + 8'h01; // RULE_18
    next_fas_frame = fas_frame;
    if (bit_pos == `E1FAS_BITS_LAST)
      next_fas_frame = !fas_frame; // RULE_18
    if ((state == E1FAS_HUNT) && pat_now)
    begin
      next_pos = `E1FAS_FAS_NEXT_BIT; // RULE_13
      next_fas_frame = 1'b1;
    end
  end

  // search sequence; everything advances only on a line bit
  always_comb
  begin
    next_state = state;
    case (state)
      E1FAS_HUNT:
        if (pat_now)
          next_state = E1FAS_NFAS; // RULE_13
      E1FAS_NFAS:
        if (at_b2)
        begin
          if (!rx_bit)
            next_state = alg_two ? E1FAS_HOLD : E1FAS_HUNT; // RULE_14 RULE_17
          else
            next_state = E1FAS_FAS;
        end
      E1FAS_HOLD:
        if (at_fas)
          next_state = E1FAS_HUNT; // RULE_17
      E1FAS_FAS:
        if (at_fas)
        begin
          if (!pat_now)
            next_state = E1FAS_HUNT; // RULE_15
          else if (extra_chk)
            next_state = E1FAS_XNFAS; // RULE_11
          else
            next_state = E1FAS_SYNC; // RULE_16
        end
      E1FAS_XNFAS:
        if (at_b2)
          next_state = rx_bit ? E1FAS_XFAS : E1FAS_HUNT; // RULE_11
      E1FAS_XFAS:
        if (at_fas)
          next_state = pat_now ? E1FAS_SYNC : E1FAS_HUNT; // RULE_11
      E1FAS_SYNC:
        next_state = E1FAS_SYNC;
      default:
        next_state = E1FAS_HUNT;
    endcase
  end

  // search registers
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state <= E1FAS_HUNT;
      bit_pos <= 8'h00;
      fas_frame <= 1'b0;
      shreg <= 7'h00;
    end
    else if (bit_tick)
    begin
      state <= next_state;
      bit_pos <= next_pos;
      fas_frame <= next_fas_frame;
      shreg <= window_bits;
    end
  end

  // ----------------------------------------------------------------
  // multiframe aligners
  // ----------------------------------------------------------------
  wire in_sync = (state == E1FAS_SYNC);
  wire si_tick = bit_tick && in_sync && at_si; // RULE_08
  wire ts16_tick = bit_tick && in_sync && at_ts16;
  wire [3:0] ts16_nibble = {shreg[2:0], rx_bit};
  logic crc_al;
  logic cas_al;

  e1fas_crcmf #(
    .WIN_CYC(CRC_WIN_CYC)
  ) u_crcmf (
    .clock(clock),
    .rst_n(rst_n),
    .enable(in_sync && sel_on(crc_sel)), // RULE_09
    .need(crc_sel), // RULE_10
    .si_tick(si_tick),
    .si_bit(rx_bit),
    .aligned(crc_al)
  );

  e1fas_casmf u_casmf (
    .clock(clock),
    .rst_n(rst_n),
    .enable(in_sync),
    .mode(cas_sel), // RULE_05
    .ts16_tick(ts16_tick),
    .nibble(ts16_nibble),
    .aligned(cas_al)
  );

  // ----------------------------------------------------------------
  // crc to non-crc interworking
  // ----------------------------------------------------------------
  logic [23:0] iw_cnt;
  wire iw_watch = iw_en && sel_on(crc_sel) && in_sync && !crc_al; // RULE_01 RULE_02
  wire iw_expire = iw_watch && !non_crc_far_end && (iw_cnt >= 24'(IW_CYC - 1));

  // the timer stops once the far end is judged non-crc
  always_ff @(posedge clock)
  begin
    if (!rst_n || !iw_watch)
    begin
      iw_cnt <= 24'h0;
      non_crc_far_end <= 1'b0;
    end
    else if (iw_expire)
      non_crc_far_end <= 1'b1; // RULE_01
    else if (!non_crc_far_end)
      iw_cnt <= iw_cnt + 24'h1;
  end

  // ----------------------------------------------------------------
  // status outputs and events
  // ----------------------------------------------------------------
  always_comb
  begin
    events = 4'h0;
    events[`E1FAS_IRQ_FAS] = in_sync && !fas_in_sync;
    events[`E1FAS_IRQ_CRC] = crc_al && !crc_mf_aligned;
    events[`E1FAS_IRQ_CAS] = cas_al && !cas_mf_aligned;
    events[`E1FAS_IRQ_IW] = iw_expire; // RULE_01
  end

  // registered copies give edge detection and flop-driven outputs
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      fas_in_sync <= 1'b0;
      crc_mf_aligned <= 1'b0;
      cas_mf_aligned <= 1'b0;
    end
    else
    begin
      fas_in_sync <= in_sync; // RULE_16
      crc_mf_aligned <= crc_al;
      cas_mf_aligned <= cas_al;
    end
  end

  // ----------------------------------------------------------------
  // transmit crc error injection
  // ----------------------------------------------------------------

  // c1 flips only while the transmit side really carries crc multiframes
  wire inject = tx_crc_err && tx_crc_mf_on && tx_c1_slot; // RULE_03 RULE_04

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      tx_bit_out <= 1'b0;
    else
      tx_bit_out <= tx_bit_in ^ inject; // RULE_03
  end
endmodule // e1fas_top
`default_nettype wire

// [tb/e1fas_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// port checker for the alignment block
// ----------------------------------------
module e1fas_asserts (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rd_data,
  input wire logic irq,
  input wire logic tx_bit_in,
  input wire logic tx_c1_slot,
  input wire logic tx_crc_mf_on,
  input wire logic tx_bit_out,
  input wire logic fas_in_sync,
  input wire logic crc_mf_aligned,
  input wire logic cas_mf_aligned,
  input wire logic non_crc_far_end
);
  logic [7:0] fs;
  logic [3:0] msk;
  logic rst_q;
  // shadow registers, since the checker cannot see inside the block
  wire logic wr_fs = reg_wr & (reg_addr == 8'h00);
  wire logic wr_msk = reg_wr & (reg_addr == 8'h02);
  wire logic inj = tx_c1_slot & tx_crc_mf_on & fs[6];
  wire logic cas_on = fs[5] ^ fs[4];
  wire logic crc_on = |fs[3:2];
  wire logic iw_ok = fs[7] & crc_on & fas_in_sync & ~crc_mf_aligned;
  wire logic rd_fs = reg_rd & (reg_addr == 8'h00);
  wire logic no_msk = (msk == 4'h0);
  // shadows follow writes with the same one-cycle latency as the block
  always_ff @(posedge clock)
  begin
    fs <= !rst_n ? 8'h00 : (wr_fs ? reg_wr_data : fs);
    msk <= !rst_n ? 4'h0 : (wr_msk ? reg_wr_data[3:0] : msk);
    rst_q <= rst_n;
  end
  default clocking cb @(posedge clock); endclocking
  // stay quiet for one more edge: the release edge still shows reset values
  default disable iff (!rst_n || !rst_q);
  chk_tx_invert: assert property (inj |=> tx_bit_out != $past(tx_bit_in))
    else $error("c1 bit not inverted");
  chk_tx_plain: assert property (!inj |=> tx_bit_out == $past(tx_bit_in))
    else $error("tx bit altered without injection");
  // aligner flop plus output flop: a disable shows two edges later
  chk_cas_off: assert property (cas_mf_aligned |-> $past(cas_on, 2))
    else $error("cas aligned while disabled");
  chk_crc_off: assert property (crc_mf_aligned |-> $past(crc_on, 2))
    else $error("crc aligned while disabled");
  chk_iw_cause: assert property ($rose(non_crc_far_end) |-> $past(iw_ok))
    else $error("interworking declared without cause");
  chk_iw_enable: assert property (non_crc_far_end |-> $past(fs[7]))
    else $error("interworking flagged while disabled");
  chk_iw_irq: assert property ($rose(non_crc_far_end) && msk[3] |-> ##[1:2] irq)
    else $error("no interworking interrupt");
  chk_irq_masked: assert property (no_msk && $past(no_msk) |-> !irq)
    else $error("irq with all masked");
  chk_sync_stays: assert property (fas_in_sync |=> fas_in_sync)
    else $error("sync dropped");
  chk_mf_order: assert property (crc_mf_aligned || cas_mf_aligned |-> fas_in_sync)
    else $error("multiframe aligned without sync");
  chk_fs_readback: assert property (rd_fs |=> reg_rd_data == $past(fs))
    else $error("framing select readback wrong");
  cover property (fas_in_sync && cas_mf_aligned);
  cover property (crc_mf_aligned);
  cover property ($rose(non_crc_far_end));
endmodule // e1fas_asserts
bind e1fas_top e1fas_asserts chk_u (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data),
  .irq(irq), .tx_bit_in(tx_bit_in), .tx_c1_slot(tx_c1_slot), .tx_crc_mf_on(tx_crc_mf_on),
  .tx_bit_out(tx_bit_out), .fas_in_sync(fas_in_sync), .crc_mf_aligned(crc_mf_aligned),
  .cas_mf_aligned(cas_mf_aligned), .non_crc_far_end(non_crc_far_end));
`default_nettype wire

// [tb/e1fas_far_end.sv]
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// far-end terminal: free running framed stream
// ----------------------------------------
module e1fas_far_end (
  input wire logic nfas_zero,
  output logic line_clk,
  output logic line_data
);
  int bitn = 0;
  int frm = 0;
  // bit value at bit b of frame f; payload idles at ones so no false pattern
  function automatic logic bit_at(input int b, input int f, input logic nz);
    if (b == 0)
      return f[0] ? 8'h2F >> (7 - f / 2) : 1'b1;
    if (b < 8)
      return f[0] ? (b == 1 ? ~nz : b != 2) : 7'h1B >> (7 - b);
    if (b >= 128 && b < 132)
      return f != 0;
    return 1'b1;
  endfunction
  // line clock runs free at four bench clocks a bit, phase unrelated
  initial
  begin
    line_clk = 1'b0;
    line_data = 1'b1;
    #7;
    forever #80 line_clk = ~line_clk;
  end
  // launch on the fall so data is settled half a bit before the rise
  always @(negedge line_clk)
  begin
    line_data <= bit_at(bitn, frm, nfas_zero);
    bitn <= (bitn == 255) ? 0 : bitn + 1;
    frm <= (bitn == 255) ? (frm + 1) % 16 : frm;
  end
endmodule // e1fas_far_end
`default_nettype wire

// [tb/e1_frame_alignment_select_test.sv]
`timescale 1ns/10ps
`default_nettype none
module e1_frame_alignment_select_test;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wr_data = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic tx_bit_in = 1'b0;
  logic tx_c1_slot = 1'b0;
  logic tx_crc_mf_on = 1'b0;
  logic nfas_zero = 1'b1;
  logic tx_go = 1'b0;
  logic rd_d = 1'b0;
  logic prev_exp = 1'b0;
  logic have_prev = 1'b0;
  logic [7:0] fs_m = 8'h00;
  logic [31:0] rng = 32'h0000_0004;
  logic [15:0] ent;
  logic [15:0] rdq[$];
  logic txq[$];
  logic [7:0] ra[5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h10};
  int error_cnt = 0;
  int compares = 0;
  wire logic [7:0] reg_rd_data;
  wire logic irq, line_clk, line_data, tx_bit_out;
  wire logic fas_in_sync, crc_mf_aligned, cas_mf_aligned, non_crc_far_end;
  wire logic [3:0] st = {non_crc_far_end, cas_mf_aligned, crc_mf_aligned, fas_in_sync};
  // short windows keep the run small: 20000 lies between one and two multiframes
  e1fas_top #(.CRC_WIN_CYC(20000), .IW_CYC(5000)) dut_u (.clock(clock), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rd_data(reg_rd_data), .irq(irq), .line_clk(line_clk), .line_data(line_data),
    .tx_bit_in(tx_bit_in), .tx_c1_slot(tx_c1_slot), .tx_crc_mf_on(tx_crc_mf_on),
    .tx_bit_out(tx_bit_out), .fas_in_sync(fas_in_sync), .crc_mf_aligned(crc_mf_aligned),
    .cas_mf_aligned(cas_mf_aligned), .non_crc_far_end(non_crc_far_end));
  e1fas_far_end far_u (.nfas_zero(nfas_zero), .line_clk(line_clk), .line_data(line_data));
  always #20 clock = ~clock;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic check8(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    rdq.push_back({m, e & m});
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
  endtask
  task automatic wait_hi(input int s, input int lim);
    int n;
    n = 0;
    while (st[s] !== 1'b1 && n < lim)
    begin
      @(posedge clock);
      n++;
    end
    check8("align", 8'h01, {7'h00, st[s]});
  endtask
  task automatic do_reset();
    @(posedge clock);
    rst_n <= 1'b0;
    tx_go <= 1'b0;
    repeat (6) @(posedge clock);
    fs_m = 8'h00;
    have_prev = 1'b0;
    txq.delete();
    rst_n <= 1'b1;
    @(posedge clock);
    tx_go <= 1'b1;
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // random transmit traffic; the note for each bit is queued when it is sampled
  always @(posedge clock)
  begin
    rd_d <= reg_rd;
    fs_m = (reg_wr && reg_addr == 8'h00) ? reg_wr_data : fs_m;
    if (tx_go)
    begin
      if (have_prev)
        txq.push_back(prev_exp);
      rng = xs(rng);
      prev_exp = rng[0] ^ (rng[1] & rng[2] & fs_m[6]);
      tx_bit_in <= rng[0];
      tx_c1_slot <= rng[1];
      tx_crc_mf_on <= rng[2];
      have_prev = 1'b1;
    end
  end
  // watcher: settled outputs are compared with the oldest note
  always @(negedge clock)
  begin
    if (rd_d && rdq.size() > 0)
    begin
      ent = rdq.pop_front();
      check8("reg_rd_data", ent[7:0], reg_rd_data & ent[15:8]);
    end
    if (txq.size() > 0)
      check8("tx_bit_out", {7'h00, txq.pop_front()}, {7'h00, tx_bit_out});
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    do_reset();
    wr(8'h03, 8'hFF);
    wr(8'h10, 8'hFF);
    foreach (ra[i])
      rd(ra[i], 8'h00, 8'hFF);
    $display("test registers done");
    wr(8'h00, 8'h70);
    repeat (4096) @(posedge clock);
    check8("sync", 8'h00, {7'h00, fas_in_sync});
    nfas_zero <= 1'b0;
    wait_hi(0, 8192);
    rd(8'h01, 8'h01, 8'h01);
    check8("irq", 8'h00, {7'h00, irq});
    wr(8'h02, 8'h01);
    repeat (3) @(negedge clock);
    check8("irq", 8'h01, {7'h00, irq});
    wr(8'h01, 8'h01);
    repeat (3) @(negedge clock);
    check8("irq", 8'h00, {7'h00, irq});
    repeat (16384) @(posedge clock);
    check8("mf", 8'h00, {6'h00, crc_mf_aligned, cas_mf_aligned});
    wr(8'h00, 8'h1B);
    wait_hi(2, 36000);
    wait_hi(1, 36000);
    rd(8'h03, 8'h07, 8'hFF);
    $display("test run a done");
    do_reset();
    wr(8'h02, 8'h08);
    wr(8'h00, 8'hAF);
    wait_hi(0, 10000);
    wait_hi(3, 8000);
    check8("irq", 8'h01, {7'h00, irq});
    wait_hi(2, 20000);
    check8("crc", 8'h00, {7'h00, crc_mf_aligned});
    rd(8'h01, 8'h08, 8'h08);
    wr(8'h00, 8'h2F);
    repeat (3) @(negedge clock);
    check8("far", 8'h00, {7'h00, non_crc_far_end});
    $display("test run b done");
    tally_and_finish();
  end
  // watchdog sized above the expected run of about 82000 cycles
  initial
  begin
    repeat (90000) @(posedge clock);
    error_cnt++;
    tally_and_finish();
  end
endmodule // e1_frame_alignment_select_test
`default_nettype wire
